// File: rtl/tcs_defs.vh
// register map, field positions and reset values of the timer channel block
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// byte offsets of the registers inside one channel window
`define TCS_OFF_COUNT      6'h10
`define TCS_OFF_CC_A       6'h14
`define TCS_OFF_CC_B       6'h18
`define TCS_OFF_CMP_C      6'h1c
`define TCS_OFF_STATUS     6'h20
`define TCS_OFF_IRQ_SET    6'h24
`define TCS_OFF_IRQ_CLR    6'h28
`define TCS_OFF_IRQ_MASK   6'h2c

// address layout: offset in [5:0], channel in [7:6], [11:8] must be zero
`define TCS_ADDR_W         12
`define TCS_CH_LSB         6
`define TCS_CH_MSB         7
`define TCS_TOP_LSB        8

// status flag positions
`define TCS_ST_WRAP        0
`define TCS_ST_OVERRUN     1
`define TCS_ST_MATCH_A     2
`define TCS_ST_MATCH_B     3
`define TCS_ST_MATCH_C     4
`define TCS_ST_CAPT_A      5
`define TCS_ST_CAPT_B      6
`define TCS_ST_TRIG        7
`define TCS_ST_CLK_RUN     16
`define TCS_ST_PIN_A       17
`define TCS_ST_PIN_B       18

// flags that may exist only in one mode
`define TCS_CAPT_ONLY      8'h62
`define TCS_WAVE_ONLY      8'h0c

// reset values
`define TCS_RST_VALUE16    16'h0000
`define TCS_RST_FLAGS      8'h00
`define TCS_RST_MASK       8'h00
`define TCS_RST_DATA       32'h0000_0000

`endif

// File: rtl/tcs_channel_regs.v
// register, sticky status and interrupt logic of a three channel timer
//
// Overview of operation
// - count register reads the live 16-bit count, upper bits zero
// - registers A and B take writes only in waveform mode; always read
// - compare C is 16-bit read/write in both modes
// - status bit 0 sets on count wrap, cleared by status read
// - bit 1 sets on second unread load of A or B, capture mode only
// - bits 2 and 3 set on match A or B, waveform mode only
// - bit 4 sets on match C in either mode, cleared by status read
// - bits 5 and 6 set on capture load of A or B, capture mode only
// - bit 7 sets on external trigger, cleared by status read
// - bit 16 shows live counter clock enable, not sticky
// - bit 17 mirrors line A: pin in capture, driven level in waveform
// - bit 18 mirrors line B: pin in capture, driven level in waveform
// - ones written to enable-set register enable the matching interrupts
// - ones written to enable-clear register disable matching interrupts
// - mask register reads which interrupts are enabled, status layout
// - mode select zero is capture, one is waveform; steers the above
`timescale 1ns/1ns
`default_nettype none
`include "tcs_defs.vh"

module tcs_channel_regs #(
  parameter NCH = 3
) (
  // clock and reset
  input  wire                     CLOCK_I,
  input  wire                     RST_I,
  // apb slave
  input  wire                     PSEL_I,
  input  wire                     PENABLE_I,
  input  wire                     PWRITE_I,
  input  wire [`TCS_ADDR_W-1:0]   PADDR_I,
  input  wire [31:0]              PWDATA_I,
  output wire [31:0]              PRDATA_O,
  output wire                     PREADY_O,
  output wire                     PSLVERR_O,
  // counting logic, one field per channel
  input  wire [16*NCH-1:0]        LIVE_COUNT_I,
  input  wire [NCH-1:0]           WAVE_I,
  input  wire [NCH-1:0]           WRAP_I,
  input  wire [NCH-1:0]           MATCH_A_I,
  input  wire [NCH-1:0]           MATCH_B_I,
  input  wire [NCH-1:0]           MATCH_C_I,
  input  wire [NCH-1:0]           CAPT_A_I,
  input  wire [NCH-1:0]           CAPT_B_I,
  input  wire [NCH-1:0]           EXT_TRIG_I,
  input  wire [NCH-1:0]           CLK_RUN_I,
  // line levels: sampled pin and driven waveform level
  input  wire [NCH-1:0]           LINE_A_PIN_I,
  input  wire [NCH-1:0]           LINE_A_DRV_I,
  input  wire [NCH-1:0]           LINE_B_PIN_I,
  input  wire [NCH-1:0]           LINE_B_DRV_I,
  // register values to the compare logic
  output wire [16*NCH-1:0]        CC_A_O,
  output wire [16*NCH-1:0]        CC_B_O,
  output wire [16*NCH-1:0]        CMP_C_O,
  // interrupts
  output wire [NCH-1:0]           CH_IRQ_O,
  output wire                     IRQ_O
);

  reg  [31:0]          prdata;
  reg                  pready;
  reg                  pslverr;
  reg                  irq_any;
  reg                  off_ok;
  reg  [31:0]          rd_sel;
  wire [5:0]           reg_off;
  wire [1:0]           chan_idx;
  wire                 hit;
  wire                 access_go;
  wire                 wr_go;
  wire                 rd_go;
  wire [32*NCH-1:0]    rd_all;
  wire [NCH-1:0]       ch_irq;

  assign reg_off  = PADDR_I[5:0];
  assign chan_idx = PADDR_I[`TCS_CH_MSB:`TCS_CH_LSB];

  // offset decode; the write-only registers are mapped and read as zero
  always @*
  begin
    case (reg_off)
      `TCS_OFF_COUNT,
      `TCS_OFF_CC_A,
      `TCS_OFF_CC_B,
      `TCS_OFF_CMP_C,
      `TCS_OFF_STATUS,
      `TCS_OFF_IRQ_SET,
      `TCS_OFF_IRQ_CLR,
      `TCS_OFF_IRQ_MASK: off_ok = 1'b1;
      default:           off_ok = 1'b0;
    endcase
  end

  assign hit = off_ok
             && (PADDR_I[`TCS_ADDR_W-1:`TCS_TOP_LSB] == 4'h0)
             && ({30'h0, chan_idx} < NCH);

  // a transfer completes at the edge where the registered pready is high
  assign access_go = PSEL_I & PENABLE_I & pready;
  assign wr_go     = access_go & PWRITE_I & hit;
  assign rd_go     = access_go & ~PWRITE_I & hit;

  // read mux across channels; unmapped reads give zero
  always @*
  begin
    rd_sel = `TCS_RST_DATA;
    if (hit)
      rd_sel = rd_all[32*chan_idx +: 32];
  end

  // one wait state: data is captured while pready rises, so the status
  // snapshot the master sees is exactly the set of flags that get cleared
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pready  <= 1'b0;
      prdata  <= `TCS_RST_DATA;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= PSEL_I & PENABLE_I & ~pready;
      if (PSEL_I & PENABLE_I & ~pready)
      begin
        prdata  <= PWRITE_I ? `TCS_RST_DATA : rd_sel;
        pslverr <= ~hit;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      localparam [1:0] CH = g;
      // private copy per channel, nothing shared
      reg  [15:0] cc_a;
      reg  [15:0] cc_b;
      reg  [15:0] cmp_c;
      reg  [7:0]  flags;
      reg  [7:0]  mask;
      reg         unread_a;
      reg         unread_b;
      reg         irq;
      reg  [31:0] rdata;
      reg  [7:0]  next_flags;
      wire        sel;
      wire        wave;
      wire [15:0] cnt;
      wire        line_a;
      wire        line_b;
      wire        load_a;
      wire        load_b;
      wire [7:0]  ev;
      wire [7:0]  clr;
      wire [7:0]  keep;

      assign sel    = (chan_idx == CH);
      assign wave   = WAVE_I[g];
      assign cnt    = LIVE_COUNT_I[16*g +: 16];
      assign load_a = CAPT_A_I[g] & ~wave;
      assign load_b = CAPT_B_I[g] & ~wave;
      // mirror source follows the mode
      assign line_a = wave ? LINE_A_DRV_I[g] : LINE_A_PIN_I[g];
      assign line_b = wave ? LINE_B_DRV_I[g] : LINE_B_PIN_I[g];

      // event vector in status layout
      assign ev[`TCS_ST_WRAP]    = WRAP_I[g];
      assign ev[`TCS_ST_OVERRUN] = (load_a & unread_a)
                                 | (load_b & unread_b);
      assign ev[`TCS_ST_MATCH_A] = MATCH_A_I[g] & wave;
      assign ev[`TCS_ST_MATCH_B] = MATCH_B_I[g] & wave;
      assign ev[`TCS_ST_MATCH_C] = MATCH_C_I[g];
      assign ev[`TCS_ST_CAPT_A]  = load_a;
      assign ev[`TCS_ST_CAPT_B]  = load_b;
      assign ev[`TCS_ST_TRIG]    = EXT_TRIG_I[g];

      // only flags shown in the read snapshot are cleared, so an event
      // landing after the snapshot survives the read
      assign clr  = (rd_go & sel & (reg_off == `TCS_OFF_STATUS))
                  ? prdata[7:0] : 8'h00;
      // mode-foreign flags are forced to zero
      assign keep = wave ? ~`TCS_CAPT_ONLY : ~`TCS_WAVE_ONLY;

      // set wins over the read clear
      always @*
      begin
        next_flags = ((flags & ~clr) | ev) & keep;
      end

      // read data of this channel's window
      always @*
      begin
        rdata = `TCS_RST_DATA;
        case (reg_off)
          `TCS_OFF_COUNT:    rdata = {16'h0000, cnt};
          `TCS_OFF_CC_A:     rdata = {16'h0000, cc_a};
          `TCS_OFF_CC_B:     rdata = {16'h0000, cc_b};
          `TCS_OFF_CMP_C:    rdata = {16'h0000, cmp_c};
          `TCS_OFF_STATUS:
          begin
            rdata[7:0]            = flags;
            rdata[`TCS_ST_CLK_RUN] = CLK_RUN_I[g];
            rdata[`TCS_ST_PIN_A]   = line_a;
            rdata[`TCS_ST_PIN_B]   = line_b;
          end
          `TCS_OFF_IRQ_MASK: rdata = {24'h000000, mask};
          default:           rdata = `TCS_RST_DATA;
        endcase
      end
      assign rd_all[32*g +: 32] = rdata;

      // storage, flags and mask
      always @(posedge CLOCK_I)
      begin
        if (RST_I)
        begin
          cc_a     <= `TCS_RST_VALUE16;
          cc_b     <= `TCS_RST_VALUE16;
          cmp_c    <= `TCS_RST_VALUE16;
          flags    <= `TCS_RST_FLAGS;
          mask     <= `TCS_RST_MASK;
          unread_a <= 1'b0;
          unread_b <= 1'b0;
          irq      <= 1'b0;
        end
        else
        begin
          // capture has priority; software writes only in waveform mode
          if (load_a)
            cc_a <= cnt;
          else if (wr_go & sel & wave & (reg_off == `TCS_OFF_CC_A))
            cc_a <= PWDATA_I[15:0];
          if (load_b)
            cc_b <= cnt;
          else if (wr_go & sel & wave & (reg_off == `TCS_OFF_CC_B))
            cc_b <= PWDATA_I[15:0];
          if (wr_go & sel & (reg_off == `TCS_OFF_CMP_C))
            cmp_c <= PWDATA_I[15:0];

          // a load marks the register unread until software reads it or the channel is in waveform mode
          if (load_a)
            unread_a <= 1'b1;
          else if ((rd_go & sel & (reg_off == `TCS_OFF_CC_A)) | wave)
            unread_a <= 1'b0;
          if (load_b)
            unread_b <= 1'b1;
          else if ((rd_go & sel & (reg_off == `TCS_OFF_CC_B)) | wave)
            unread_b <= 1'b0;

          flags <= next_flags;

          if (wr_go & sel & (reg_off == `TCS_OFF_IRQ_SET))
            mask <= mask | PWDATA_I[7:0];
          else if (wr_go & sel & (reg_off == `TCS_OFF_IRQ_CLR))
            mask <= mask & ~PWDATA_I[7:0];

          // one cycle behind the flags, so the pin comes from a flop
          irq <= |(flags & mask);
        end
      end

      assign CC_A_O[16*g +: 16]  = cc_a;
      assign CC_B_O[16*g +: 16]  = cc_b;
      assign CMP_C_O[16*g +: 16] = cmp_c;
      assign ch_irq[g]           = irq;
    end
  endgenerate

  // shared interrupt line, registered
  always @(posedge CLOCK_I)
  begin
    if (RST_I)
      irq_any <= 1'b0;
    else
      irq_any <= |ch_irq;
  end

  assign PRDATA_O  = prdata;
  assign PREADY_O  = pready;
  assign PSLVERR_O = pslverr;
  assign CH_IRQ_O  = ch_irq;
  assign IRQ_O     = irq_any;

endmodule // tcs_channel_regs
`default_nettype wire

// File: dv/tcs_line_model.sv
// far side model: line a and b levels for every timer channel
`timescale 1ns/1ns
`default_nettype none
module tcs_line_model #(
  parameter NCH = 3
) (
  // levels requested by the bench
  input  wire logic [NCH-1:0] lvl_a_i,
  input  wire logic [NCH-1:0] lvl_b_i,
  // levels seen by the block
  output logic      [NCH-1:0] pin_a_o,
  output logic      [NCH-1:0] pin_b_o,
  output logic      [NCH-1:0] drv_a_o,
  output logic      [NCH-1:0] drv_b_o
);
  // driven copy is inverted so a wrong mirror select shows as a flipped bit
  assign pin_a_o = lvl_a_i;
  assign pin_b_o = lvl_b_i;
  assign drv_a_o = ~lvl_a_i;
  assign drv_b_o = ~lvl_b_i;
endmodule // tcs_line_model
`default_nettype wire

// File: dv/tcs_chk_assertions.sv
// concurrent checks on the ports of the timer channel register block
`timescale 1ns/1ns
`default_nettype none
`include "tcs_defs.vh"
module tcs_chk #(
  parameter NCH = 3
) (
  // clock, reset and bus
  input wire logic              CLOCK_I,
  input wire logic              RST_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [11:0]       PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  // counting side
  input wire logic [16*NCH-1:0] LIVE_COUNT_I,
  input wire logic [NCH-1:0]    WAVE_I,
  input wire logic [NCH-1:0]    CAPT_A_I,
  input wire logic [NCH-1:0]    CLK_RUN_I,
  input wire logic [NCH-1:0]    LINE_A_PIN_I,
  input wire logic [NCH-1:0]    LINE_A_DRV_I,
  input wire logic [NCH-1:0]    LINE_B_PIN_I,
  input wire logic [NCH-1:0]    LINE_B_DRV_I,
  // register values and interrupts
  input wire logic [16*NCH-1:0] CC_A_O,
  input wire logic [16*NCH-1:0] CMP_C_O,
  input wire logic [NCH-1:0]    CH_IRQ_O,
  input wire logic              IRQ_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // completed transfers; read data is judged only on mapped addresses
  wire       done = PSEL_I & PENABLE_I & PREADY_O;
  wire       rd   = done & ~PWRITE_I & ~PSLVERR_O;
  wire [1:0] ch   = PADDR_I[7:6];
  wire       st   = rd & (PADDR_I[5:0] == `TCS_OFF_STATUS);
  count_read_a: assert property (
    rd && PADDR_I[5:0] == `TCS_OFF_COUNT |->
    PRDATA_O == {16'h0000, $past(LIVE_COUNT_I[ch*16 +: 16])})
    else $error("count read differs from live count");
  clock_bit_a: assert property (
    st |-> PRDATA_O[16] == $past(CLK_RUN_I[ch]))
    else $error("clock running bit wrong");
  mirror_a_bit_a: assert property (
    st |-> PRDATA_O[17] ==
    $past(WAVE_I[ch] ? LINE_A_DRV_I[ch] : LINE_A_PIN_I[ch]))
    else $error("line a mirror wrong");
  mirror_b_bit_a: assert property (
    st |-> PRDATA_O[18] ==
    $past(WAVE_I[ch] ? LINE_B_DRV_I[ch] : LINE_B_PIN_I[ch]))
    else $error("line b mirror wrong");
  mode_flags_a: assert property (
    st |-> (PRDATA_O[7:0] & ($past(WAVE_I[ch]) ? `TCS_CAPT_ONLY
    : `TCS_WAVE_ONLY)) == 8'h00) else $error("flag set in wrong mode");
  irq_or_a: assert property (
    IRQ_O == $past(|CH_IRQ_O)) else $error("irq not or of channels");
  cc_a_hold_a: assert property (
    !$past(WAVE_I[0]) && !$past(CAPT_A_I[0]) |-> $stable(CC_A_O[15:0]))
    else $error("register a changed in capture mode");
  cc_a_load_a: assert property (
    $past(CAPT_A_I[0] & ~WAVE_I[0]) |->
    CC_A_O[15:0] == $past(LIVE_COUNT_I[15:0]))
    else $error("capture did not load count");
  cmp_c_write_a: assert property (
    done && PWRITE_I && PADDR_I == `TCS_OFF_CMP_C |=>
    CMP_C_O[15:0] == $past(PWDATA_I[15:0])) else $error("c write lost");
  cover property (st && PRDATA_O[1]);
  cover property ($rose(IRQ_O));
  cover property (PREADY_O && PSLVERR_O);
endmodule // tcs_chk
bind tcs_channel_regs tcs_chk #(.NCH(NCH)) u_tcs_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .LIVE_COUNT_I(LIVE_COUNT_I), .WAVE_I(WAVE_I),
  .CAPT_A_I(CAPT_A_I), .CLK_RUN_I(CLK_RUN_I),
  .LINE_A_PIN_I(LINE_A_PIN_I), .LINE_A_DRV_I(LINE_A_DRV_I),
  .LINE_B_PIN_I(LINE_B_PIN_I), .LINE_B_DRV_I(LINE_B_DRV_I),
  .CC_A_O(CC_A_O), .CMP_C_O(CMP_C_O), .CH_IRQ_O(CH_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// File: dv/tb_tcs_channel_regs.sv
// self-checking bench for the timer channel register block
`timescale 1ns/1ns
`default_nettype none
`include "tcs_defs.vh"
module tb_tcs_channel_regs;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  wave = 3'h0;
  logic [2:0]  run = 3'h0;
  logic [2:0]  la = 3'h0;
  logic [2:0]  lb = 3'h0;
  logic [2:0]  ev [0:6] = '{default: 3'h0};
  logic [47:0] cnt = {16'h0000, 16'hbeef, 16'h1234};
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  wire  [2:0]  ch_irq, pa, pb, da, db;
  wire  [47:0] cca, ccb, ccc;
  int          fails = 0;
  int          total_checks = 0;
  // rows: event index, mode, expected low status byte
  logic [11:0] rows [0:11] = '{{3'd0, 1'b0, 8'h01}, {3'd1, 1'b1, 8'h04},
    {3'd1, 1'b0, 8'h00}, {3'd2, 1'b1, 8'h08}, {3'd2, 1'b0, 8'h00},
    {3'd3, 1'b0, 8'h10}, {3'd3, 1'b1, 8'h10}, {3'd4, 1'b0, 8'h20},
    {3'd4, 1'b1, 8'h00}, {3'd5, 1'b0, 8'h40}, {3'd5, 1'b1, 8'h00},
    {3'd6, 1'b1, 8'h80}};
  tcs_line_model #(.NCH(3)) u_tcs_line_model (.lvl_a_i(la), .lvl_b_i(lb),
    .pin_a_o(pa), .pin_b_o(pb), .drv_a_o(da), .drv_b_o(db));
  tcs_channel_regs #(.NCH(3)) u_tcs_channel_regs (.CLOCK_I(clk),
    .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .LIVE_COUNT_I(cnt),
    .WAVE_I(wave), .WRAP_I(ev[0]), .MATCH_A_I(ev[1]), .MATCH_B_I(ev[2]),
    .MATCH_C_I(ev[3]), .CAPT_A_I(ev[4]), .CAPT_B_I(ev[5]),
    .EXT_TRIG_I(ev[6]), .CLK_RUN_I(run), .LINE_A_PIN_I(pa),
    .LINE_A_DRV_I(da), .LINE_B_PIN_I(pb), .LINE_B_DRV_I(db),
    .CC_A_O(cca), .CC_B_O(ccb), .CMP_C_O(ccc), .CH_IRQ_O(ch_irq),
    .IRQ_O(irq));
  task conclude;
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // answer is sampled at the falling edge so it has settled; release
  // happens only after the rising edge that completes the transfer
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(negedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(negedge clk);
        n++;
      end
      if (n == 20)
        fails++;
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  // one-cycle event pulse on channel 0
  task fire(input int k);
    @(posedge clk);
    ev[k] <= 3'b001;
    @(posedge clk);
    ev[k] <= 3'b000;
  endtask
  initial
  forever #50 clk = ~clk;
  initial
  begin
    #3000000;
    fails++;
    conclude;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `TCS_OFF_CMP_C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `TCS_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      wave[0] <= rows[i][8];
      fire(rows[i][11:9]);
      apb(1'b0, `TCS_OFF_STATUS, 32'h0);
      chk(rd[7:0], rows[i][7:0]);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'b0, 12'h050, 32'h0);
    chk(rd, 32'h0000beef);
    // capture mode refuses the write, waveform mode takes it
    wave[0] <= 1'b0;
    apb(1'b1, `TCS_OFF_CC_A, 32'habcd5555);
    apb(1'b0, `TCS_OFF_CC_A, 32'h0);
    chk(rd, 32'h00001234);
    wave[0] <= 1'b1;
    apb(1'b1, `TCS_OFF_CC_A, 32'habcd5555);
    apb(1'b0, `TCS_OFF_CC_A, 32'h0);
    chk(rd, 32'h00005555);
    apb(1'b1, 12'h09c, 32'h00007777);
    apb(1'b0, 12'h09c, 32'h0);
    chk(rd, 32'h00007777);
    // second unread capture of a gives overrun beside the load flag
    wave[0] <= 1'b0;
    apb(1'b0, `TCS_OFF_CC_A, 32'h0);
    fire(4);
    fire(4);
    apb(1'b0, `TCS_OFF_STATUS, 32'h0);
    chk(rd[7:0], 8'h22);
    run <= 3'b001;
    la <= 3'b001;
    for (int w = 0; w < 2; w++)
    begin
      wave[0] <= w[0];
      apb(1'b0, `TCS_OFF_STATUS, 32'h0);
      chk(rd[18:16], w ? 3'b101 : 3'b011);
    end
    apb(1'b1, `TCS_OFF_IRQ_SET, 32'h00000011);
    apb(1'b1, `TCS_OFF_IRQ_SET, 32'h0);
    apb(1'b0, `TCS_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h00000011);
    apb(1'b1, `TCS_OFF_IRQ_CLR, 32'h00000001);
    apb(1'b0, `TCS_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h00000010);
    // masked wrap stays quiet, match c raises channel 0 only
    fire(0);
    repeat (4) @(negedge clk);
    chk({ch_irq, irq}, 4'h0);
    fire(3);
    repeat (3) @(negedge clk);
    chk({ch_irq, irq}, 4'h3);
    apb(1'b0, `TCS_OFF_STATUS, 32'h0);
    chk(rd[7:0], 8'h11);
    repeat (4) @(negedge clk);
    chk({ch_irq, irq}, 4'h0);
    conclude;
  end
endmodule // tb_tcs_channel_regs
`default_nettype wire
